/* rtl/ppp_defines.vh */
// constants for the parallel programming port
`ifndef PPP_DEFINES_VH
`define PPP_DEFINES_VH

// ****************************************
// strobe actions, byte selects
// ****************************************
`define PPP_ACT_ADDR     2'h0
`define PPP_ACT_DATA     2'h1
`define PPP_ACT_CMD      2'h2
`define PPP_BS_LO        2'h0
`define PPP_BS_HI        2'h1
`define PPP_BS_EXT       2'h2
`define PPP_RD_FUSE_LO   2'h0
`define PPP_RD_LOCK      2'h1
`define PPP_RD_FUSE_EXT  2'h2
`define PPP_RD_FUSE_HI   2'h3

// ****************************************
// command codes
// ****************************************
`define PPP_CMD_NOP      8'h00
`define PPP_CMD_ERASE    8'h80
`define PPP_CMD_WR_FUSE  8'h40
`define PPP_CMD_WR_LOCK  8'h20
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EEP   8'h11
`define PPP_CMD_RD_SIG   8'h08
`define PPP_CMD_RD_FUSE  8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EEP   8'h03

// ****************************************
// reset and erased values
// ****************************************
`define PPP_FUSE_LO_RST  8'h5E
`define PPP_FUSE_HI_RST  8'hD9
`define PPP_FUSE_EXT_RST 8'hF4
`define PPP_ERASED_BYTE  8'hFF
`define PPP_ERASED_WORD  16'hFFFF
`define PPP_EEKEEP_BIT   3

// ****************************************
// pin vector layout
// ****************************************
`define PPP_PIN_W        17
`define PPP_PIN_XTAL     8
`define PPP_PIN_XA0      9
`define PPP_PIN_XA1      10
`define PPP_PIN_BS1      11
`define PPP_PIN_BS2      12
`define PPP_PIN_PAGE_BUFFER_LATCH    13
`define PPP_PIN_WR       14
`define PPP_PIN_OE       15
`define PPP_PIN_HV       16
`define PPP_PIN_IDLE     17'h0_C000
`define PPP_ENTRY_PAT    4'h0

// ****************************************
// timing
// ****************************************
`define PPP_CLK_NS       5
`define PPP_GUARD_NS     100
`define PPP_GUARD_CYC    ((`PPP_GUARD_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)

`endif

/* rtl/ppp_top.v */
// parallel programming port: pin decode, page buffer and nonvolatile arrays
//
// Summary of operation
// - ready_busy_flag low while an operation runs, high when a new command can be accepted.
// - data bus driven only while output enable is low, input otherwise.
// - byte selects pick address byte, fuse byte or fuse/lock read byte.
// - page latch, both strobe actions and low byte select at zero enter mode.
// - clock strobe rising edge loads address, data or command; 11 idles.
// - data load stores low byte when low select is 0, else high byte.
// - decode erase, fuse, lock, flash and eeprom write commands.
// - decode signature, fuse/lock, flash and eeprom read commands.
// - flash page is 64 words; word bits 5..0, page bits 12..6.
// - eeprom page is 4 bytes; byte bits 1..0, page bits 8..2.
// - entry pins changing within 100 ns of high voltage abort mode entry.
// - command and address stay loaded across operations.
// - chip erase clears flash, eeprom and lock bits; keep fuse saves eeprom.
// - lock bits reset only after memory erase has finished.
// - write strobe low pulse after erase command starts erase, busy low.
// - page latch rising edge moves loaded data bytes into the page buffer.
// - page buffer collects a page, written in one operation.
// - address bits above the word/byte bits serve as page number during page write.
// - write strobe with selects 00 programs buffered page, busy until done.
// - command 00 is a no-operation that ends page programming.
`include "ppp_defines.vh"
`default_nettype none

module ppp_top #(
  parameter FLASH_AW    = 13,
  parameter EEP_AW      = 9,
  parameter PAGE_WB     = 6,
  parameter EPAGE_WB    = 2,
  parameter HOLD_CYCLES = 16,
  parameter [7:0] SIG_BYTE0 = 8'h5A,  // arbitrary value
  parameter [7:0] SIG_BYTE1 = 8'h3C,  // arbitrary value
  parameter [7:0] SIG_BYTE2 = 8'h6B,  // arbitrary value
  parameter [7:0] CAL_BYTE  = 8'h80   // arbitrary value
) (
  input  wire       clk,
  input  wire       reset,
  input  wire       hv_reset_detect,
  input  wire       clock_strobe_input,
  input  wire       strobe_action_0,
  input  wire       strobe_action_1,
  input  wire       byte_select_lo,
  input  wire       byte_select_hi,
  input  wire       page_buffer_latch,
  input  wire       write_strobe_n,
  input  wire       data_out_enable_n,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe,
  output reg        ready_busy_flag,
  output reg        prog_mode
);

  localparam CW         = FLASH_AW + 1;
  localparam FLASH_DEP  = 1 << FLASH_AW;
  localparam EEP_DEP    = 1 << EEP_AW;
  localparam PAGE_DEP   = 1 << PAGE_WB;
  localparam [CW-1:0] FLASH_LAST = FLASH_DEP - 1;
  localparam [CW-1:0] EEP_DEPTH  = EEP_DEP;
  localparam [CW-1:0] PAGE_LAST  = PAGE_DEP - 1;
  localparam [CW-1:0] EPAGE_LAST = (1 << EPAGE_WB) - 1;
  localparam [CW-1:0] HOLD_LAST  = HOLD_CYCLES - 1;
  localparam [7:0]    GUARD_LAST = `PPP_GUARD_CYC - 1;

  // entry states
  localparam [1:0] E_OFF   = 2'h0;
  localparam [1:0] E_GUARD = 2'h1;
  localparam [1:0] E_ON    = 2'h2;
  localparam [1:0] E_FAIL  = 2'h3;
  // operation states
  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_ERASE  = 3'h1;
  localparam [2:0] S_LOCK   = 3'h2;
  localparam [2:0] S_PAGE_F = 3'h3;
  localparam [2:0] S_PAGE_E = 3'h4;
  localparam [2:0] S_HOLD   = 3'h5;

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [`PPP_PIN_W-1:0] pins_raw;
  reg  [`PPP_PIN_W-1:0] sync1_reg;
  reg  [`PPP_PIN_W-1:0] sync2_reg;
  reg  [`PPP_PIN_W-1:0] sync3_reg;
  reg  [`PPP_PIN_W-1:0] pin_reg;
  reg  [`PPP_PIN_W-1:0] pin_prev_reg;

  assign pins_raw = {hv_reset_detect, data_out_enable_n, write_strobe_n, page_buffer_latch,
                     byte_select_hi, byte_select_lo, strobe_action_1, strobe_action_0,
                     clock_strobe_input, data_in};

  // a bit moves only once stages two and three agree
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_reg    <= `PPP_PIN_IDLE;
      sync2_reg    <= `PPP_PIN_IDLE;
      sync3_reg    <= `PPP_PIN_IDLE;
      pin_reg      <= `PPP_PIN_IDLE;
      pin_prev_reg <= `PPP_PIN_IDLE;
    end else begin
      sync1_reg    <= pins_raw;
      sync2_reg    <= sync1_reg;
      sync3_reg    <= sync2_reg;
      pin_reg      <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg | sync3_reg));
      pin_prev_reg <= pin_reg;
    end
  end

  wire [7:0] pin_data    = pin_reg[7:0];
  wire       strobe_rise = pin_reg[`PPP_PIN_XTAL] & ~pin_prev_reg[`PPP_PIN_XTAL];
  wire       latch_rise  = pin_reg[`PPP_PIN_PAGE_BUFFER_LATCH] & ~pin_prev_reg[`PPP_PIN_PAGE_BUFFER_LATCH];
  wire       wr_fall     = ~pin_reg[`PPP_PIN_WR] & pin_prev_reg[`PPP_PIN_WR];
  wire       oe_n        = pin_reg[`PPP_PIN_OE];
  wire       hv_on       = pin_reg[`PPP_PIN_HV];
  wire [1:0] action      = {pin_reg[`PPP_PIN_XA1], pin_reg[`PPP_PIN_XA0]};
  wire [1:0] bsel        = {pin_reg[`PPP_PIN_BS2], pin_reg[`PPP_PIN_BS1]};
  wire [3:0] entry_pat   = {pin_reg[`PPP_PIN_PAGE_BUFFER_LATCH], pin_reg[`PPP_PIN_XA1],
                            pin_reg[`PPP_PIN_XA0], pin_reg[`PPP_PIN_BS1]};

  // ****************************************
  // mode entry
  // ****************************************
  reg [1:0] entry_state_reg;
  reg [7:0] guard_cnt_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      entry_state_reg <= E_OFF;
      guard_cnt_reg   <= 8'h00;
    end else if (!hv_on) begin
      entry_state_reg <= E_OFF;
      guard_cnt_reg   <= 8'h00;
    end else begin
      case (entry_state_reg)
        E_OFF: begin
          guard_cnt_reg   <= 8'h00;
          entry_state_reg <= (entry_pat == `PPP_ENTRY_PAT) ? E_GUARD : E_FAIL;
        end
        E_GUARD: begin
          guard_cnt_reg <= guard_cnt_reg + 8'h01;
          if (entry_pat != `PPP_ENTRY_PAT)
            entry_state_reg <= E_FAIL;
          else if (guard_cnt_reg == GUARD_LAST)
            entry_state_reg <= E_ON;
        end
        // failure holds until high voltage drops
        E_ON:    entry_state_reg <= E_ON;
        E_FAIL:  entry_state_reg <= E_FAIL;
        default: entry_state_reg <= E_OFF;
      endcase
    end
  end

  wire prog_on = (entry_state_reg == E_ON);

  // ****************************************
  // storage
  // ****************************************
  reg [15:0] flash_mem [0:FLASH_DEP-1];
  reg [7:0]  eep_mem   [0:EEP_DEP-1];
  reg [15:0] page_buf  [0:PAGE_DEP-1];

  reg [7:0]    cmd_reg;
  reg [7:0]    addr_lo_reg;
  reg [7:0]    addr_hi_reg;
  reg [7:0]    addr_ext_reg;
  reg [7:0]    data_lo_reg;
  reg [7:0]    data_hi_reg;
  reg [7:0]    fuse_lo_reg;
  reg [7:0]    fuse_hi_reg;
  reg [7:0]    fuse_ext_reg;
  reg [7:0]    lock_reg;
  reg [2:0]    op_state_reg;
  reg [2:0]    op_state_next;
  reg [CW-1:0] op_cnt_reg;

  wire [23:0] full_addr = {addr_ext_reg, addr_hi_reg, addr_lo_reg};
  wire        idle      = (op_state_reg == S_IDLE);
  wire        accept    = prog_on & idle;
  wire        eep_keep  = ~fuse_hi_reg[`PPP_EEKEEP_BIT];

  // ****************************************
  // array write ports
  // ****************************************
  reg                flash_we;
  reg [FLASH_AW-1:0] flash_wa;
  reg [15:0]         flash_wd;
  reg                eep_we;
  reg [EEP_AW-1:0]   eep_wa;
  reg [7:0]          eep_wd;

  always @* begin
    flash_we = 1'b0;
    flash_wa = op_cnt_reg[FLASH_AW-1:0];
    flash_wd = `PPP_ERASED_WORD;
    eep_we   = 1'b0;
    eep_wa   = op_cnt_reg[EEP_AW-1:0];
    eep_wd   = `PPP_ERASED_BYTE;
    case (op_state_reg)
      S_ERASE: begin
        flash_we = 1'b1;
        eep_we   = ~eep_keep & (op_cnt_reg < EEP_DEPTH);
      end
      S_PAGE_F: begin
        flash_we = 1'b1;
        flash_wa = {full_addr[FLASH_AW-1:PAGE_WB], op_cnt_reg[PAGE_WB-1:0]};
        flash_wd = page_buf[op_cnt_reg[PAGE_WB-1:0]];
      end
      S_PAGE_E: begin
        eep_we = 1'b1;
        eep_wa = {full_addr[EEP_AW-1:EPAGE_WB], op_cnt_reg[EPAGE_WB-1:0]};
        eep_wd = page_buf[op_cnt_reg[EPAGE_WB-1:0]][7:0];
      end
      default: begin
        flash_we = 1'b0;
      end
    endcase
  end

  // arrays carry no reset, like the cells they stand for
  always @(posedge clk) begin
    if (flash_we)
      flash_mem[flash_wa] <= flash_wd;
    if (eep_we)
      eep_mem[eep_wa] <= eep_wd;
    if (accept && latch_rise && cmd_reg == `PPP_CMD_WR_FLASH)
      page_buf[addr_lo_reg[PAGE_WB-1:0]] <= {data_hi_reg, data_lo_reg};
    else if (accept && latch_rise && cmd_reg == `PPP_CMD_WR_EEP)
      page_buf[addr_lo_reg[EPAGE_WB-1:0]] <= {8'h00, data_lo_reg};
  end

  // ****************************************
  // operation sequencer
  // ****************************************
  always @* begin
    op_state_next = op_state_reg;
    case (op_state_reg)
      S_IDLE: begin
        if (accept && wr_fall) begin
          case (cmd_reg)
            `PPP_CMD_ERASE:    op_state_next = S_ERASE;
            `PPP_CMD_WR_FLASH: op_state_next = (bsel == `PPP_BS_LO) ? S_PAGE_F : S_IDLE;
            `PPP_CMD_WR_EEP:   op_state_next = (bsel == `PPP_BS_LO) ? S_PAGE_E : S_IDLE;
            `PPP_CMD_WR_FUSE:  op_state_next = (bsel == 2'h3) ? S_IDLE : S_HOLD;
            `PPP_CMD_WR_LOCK:  op_state_next = S_HOLD;
            default:           op_state_next = S_IDLE;
          endcase
        end
      end
      S_ERASE:  op_state_next = (op_cnt_reg == FLASH_LAST) ? S_LOCK : S_ERASE;
      S_LOCK:   op_state_next = S_HOLD;
      S_PAGE_F: op_state_next = (op_cnt_reg == PAGE_LAST) ? S_HOLD : S_PAGE_F;
      S_PAGE_E: op_state_next = (op_cnt_reg == EPAGE_LAST) ? S_HOLD : S_PAGE_E;
      S_HOLD:   op_state_next = (op_cnt_reg == HOLD_LAST) ? S_IDLE : S_HOLD;
      default:  op_state_next = S_IDLE;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      op_state_reg <= S_IDLE;
      op_cnt_reg   <= {CW{1'b0}};
    end else begin
      op_state_reg <= op_state_next;
      op_cnt_reg   <= (op_state_next != op_state_reg) ? {CW{1'b0}}
                      : op_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // load decode and nonvolatile bits
  // ****************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_reg      <= `PPP_CMD_NOP;
      addr_lo_reg  <= 8'h00;
      addr_hi_reg  <= 8'h00;
      addr_ext_reg <= 8'h00;
      data_lo_reg  <= 8'h00;
      data_hi_reg  <= 8'h00;
      fuse_lo_reg  <= `PPP_FUSE_LO_RST;
      fuse_hi_reg  <= `PPP_FUSE_HI_RST;
      fuse_ext_reg <= `PPP_FUSE_EXT_RST;
      lock_reg     <= `PPP_ERASED_BYTE;
    end else begin
      if (accept && strobe_rise) begin
        case (action)
          `PPP_ACT_ADDR: begin
            case (bsel)
              `PPP_BS_LO:  addr_lo_reg  <= pin_data;
              `PPP_BS_HI:  addr_hi_reg  <= pin_data;
              `PPP_BS_EXT: addr_ext_reg <= pin_data;
              default:     addr_lo_reg  <= addr_lo_reg;
            endcase
          end
          `PPP_ACT_DATA: begin
            if (bsel[0])
              data_hi_reg <= pin_data;
            else
              data_lo_reg <= pin_data;
          end
          `PPP_ACT_CMD: begin
            case (pin_data)
              `PPP_CMD_NOP, `PPP_CMD_ERASE, `PPP_CMD_WR_FUSE, `PPP_CMD_WR_LOCK,
              `PPP_CMD_WR_FLASH, `PPP_CMD_WR_EEP, `PPP_CMD_RD_SIG, `PPP_CMD_RD_FUSE,
              `PPP_CMD_RD_FLASH, `PPP_CMD_RD_EEP: cmd_reg <= pin_data;
              default:                            cmd_reg <= cmd_reg;
            endcase
          end
          default: cmd_reg <= cmd_reg;
        endcase
      end
      if (op_state_reg == S_IDLE && op_state_next == S_HOLD && cmd_reg == `PPP_CMD_WR_FUSE) begin
        case (bsel)
          `PPP_BS_LO:  fuse_lo_reg  <= data_lo_reg;
          `PPP_BS_HI:  fuse_hi_reg  <= data_lo_reg;
          `PPP_BS_EXT: fuse_ext_reg <= data_lo_reg;
          default:     fuse_lo_reg  <= fuse_lo_reg;
        endcase
      end
      // lock bits only ever go programmed here
      if (op_state_reg == S_IDLE && op_state_next == S_HOLD && cmd_reg == `PPP_CMD_WR_LOCK)
        lock_reg <= lock_reg & data_lo_reg;
      if (op_state_reg == S_LOCK)
        lock_reg <= `PPP_ERASED_BYTE;
    end
  end

  // ****************************************
  // read path and outputs
  // ****************************************
  reg [7:0] read_byte;
  reg [7:0] sig_byte;

  wire [15:0] flash_rd = flash_mem[full_addr[FLASH_AW-1:0]];

  always @* begin
    case (addr_lo_reg)
      8'h00:   sig_byte = SIG_BYTE0;
      8'h01:   sig_byte = SIG_BYTE1;
      8'h02:   sig_byte = SIG_BYTE2;
      default: sig_byte = 8'h00;
    endcase
    case (cmd_reg)
      `PPP_CMD_RD_FLASH: read_byte = bsel[0] ? flash_rd[15:8] : flash_rd[7:0];
      `PPP_CMD_RD_EEP:   read_byte = eep_mem[full_addr[EEP_AW-1:0]];
      `PPP_CMD_RD_SIG:   read_byte = bsel[0] ? CAL_BYTE : sig_byte;
      `PPP_CMD_RD_FUSE: begin
        case (bsel)
          `PPP_RD_FUSE_LO:  read_byte = fuse_lo_reg;
          `PPP_RD_LOCK:     read_byte = lock_reg;
          `PPP_RD_FUSE_EXT: read_byte = fuse_ext_reg;
          default:          read_byte = fuse_hi_reg;
        endcase
      end
      default: read_byte = 8'h00;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      data_out        <= 8'h00;
      data_oe         <= 1'b0;
      ready_busy_flag <= 1'b0;
      prog_mode       <= 1'b0;
    end else begin
      data_out        <= read_byte;
      data_oe         <= prog_on & ~oe_n;
      // ready only when idle in mode
      ready_busy_flag <= prog_on & (op_state_next == S_IDLE);
      prog_mode       <= prog_on;
    end
  end

endmodule // ppp_top

`default_nettype wire

/* bench/ppp_top_sva.sv */
// assertion checker for the parallel programming port
`default_nettype none
module ppp_top_sva #(
  parameter FLASH_AW    = 13,
  parameter HOLD_CYCLES = 16
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       hv_reset_detect,
  input wire logic       clock_strobe_input,
  input wire logic       strobe_action_0,
  input wire logic       strobe_action_1,
  input wire logic       byte_select_lo,
  input wire logic       byte_select_hi,
  input wire logic       page_buffer_latch,
  input wire logic       write_strobe_n,
  input wire logic       data_out_enable_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       ready_busy_flag,
  input wire logic       prog_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  // erase is the longest busy span
  localparam int BUSY_MAX = (1 << FLASH_AW) + HOLD_CYCLES + 12;
  localparam int BUSY_MIN = HOLD_CYCLES - 1;
  logic [15:0] busy_cnt;
  wire  [3:0]  entry_pat = {page_buffer_latch, strobe_action_1, strobe_action_0, byte_select_lo};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ****************************************
  // busy span counter
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_cnt <= 16'h0000;
    end else if (prog_mode && !ready_busy_flag) begin
      busy_cnt <= busy_cnt + 16'h0001;
    end else begin
      busy_cnt <= 16'h0000;
    end
  end
  property p_rdy_mode; ready_busy_flag |-> prog_mode; endproperty
  a_rdy_mode: assert property (p_rdy_mode) else $error("ready outside mode");
  property p_busy_max; prog_mode |-> busy_cnt <= BUSY_MAX; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_busy_min;
    $rose(ready_busy_flag) && busy_cnt != 16'h0000 |-> busy_cnt >= BUSY_MIN;
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_busy_cause; $fell(ready_busy_flag) && prog_mode |-> !$past(write_strobe_n, 3);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
  property p_oe_cause; $rose(data_oe) |-> prog_mode && !$past(data_out_enable_n, 3); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven unasked");
  property p_oe_off; data_out_enable_n [*8] |-> !data_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven while disabled");
  property p_entry;
    $rose(prog_mode) |-> hv_reset_detect && $past(entry_pat, 8) == 4'h0
      && $past(entry_pat, 16) == 4'h0;
  endproperty
  a_entry: assert property (p_entry) else $error("entry with bad pattern");
  property p_mode_hold; $fell(prog_mode) |-> !$past(hv_reset_detect, 2); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode lost with voltage on");
  property p_mode_drop; !hv_reset_detect [*8] |-> !prog_mode; endproperty
  a_mode_drop: assert property (p_mode_drop) else $error("mode kept without voltage");
endmodule // ppp_top_sva

bind ppp_top ppp_top_sva #(.FLASH_AW(FLASH_AW), .HOLD_CYCLES(HOLD_CYCLES)) i_sva (
  .clk(clk), .reset(reset), .hv_reset_detect(hv_reset_detect),
  .clock_strobe_input(clock_strobe_input), .strobe_action_0(strobe_action_0),
  .strobe_action_1(strobe_action_1), .byte_select_lo(byte_select_lo),
  .byte_select_hi(byte_select_hi), .page_buffer_latch(page_buffer_latch),
  .write_strobe_n(write_strobe_n), .data_out_enable_n(data_out_enable_n),
  .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .ready_busy_flag(ready_busy_flag), .prog_mode(prog_mode));
`default_nettype wire

/* bench/ppp_prog_model.sv */
// programmer model driving the parallel programming pins
`default_nettype none
module ppp_prog_model (
  input  wire logic       clk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  input  wire logic       ready_busy_flag,
  output wire logic [7:0] data_bus,
  output logic            hv_reset_detect,
  output logic            clock_strobe_input,
  output logic            strobe_action_0,
  output logic            strobe_action_1,
  output logic            byte_select_lo,
  output logic            byte_select_hi,
  output logic            page_buffer_latch,
  output logic            write_strobe_n,
  output logic            data_out_enable_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] drv_data;
  logic       busy_seen;
  // device owns bus when enabled; inverse value so a float never matches
  assign data_bus = data_oe ? data_out : (data_out_enable_n ? drv_data : ~drv_data);
  initial begin
    {hv_reset_detect, clock_strobe_input, strobe_action_0, strobe_action_1} = 4'h0;
    {byte_select_lo, byte_select_hi, page_buffer_latch} = 3'h0;
    {write_strobe_n, data_out_enable_n} = 2'h3;
    drv_data = 8'h00;
    busy_seen = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic enter(input logic [3:0] pat, input logic glitch);
    @(posedge clk);
    hv_reset_detect <= 1'b0;
    repeat (6) begin
      step(2);
      clock_strobe_input <= ~clock_strobe_input;
    end
    step(1);
    {page_buffer_latch, strobe_action_1, strobe_action_0, byte_select_lo} <= pat;
    step(21);
    hv_reset_detect <= 1'b1;
    // glitch only when a failed entry is wanted
    if (glitch) begin
      step(6);
      byte_select_lo <= 1'b1;
      step(8);
      byte_select_lo <= 1'b0;
    end
    step(10000);
  endtask
  task automatic leave();
    @(posedge clk);
    hv_reset_detect <= 1'b0;
    step(12);
  endtask
  // pins held 10 clocks: pin path needs 5
  task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] val);
    @(posedge clk);
    {strobe_action_1, strobe_action_0} <= act;
    {byte_select_hi, byte_select_lo} <= bs;
    drv_data <= val;
    step(10);
    clock_strobe_input <= 1'b1;
    step(10);
    clock_strobe_input <= 1'b0;
    step(10);
  endtask
  task automatic latch();
    @(posedge clk);
    page_buffer_latch <= 1'b1;
    step(10);
    page_buffer_latch <= 1'b0;
    step(10);
  endtask
  task automatic wr(input logic [1:0] bs);
    @(posedge clk);
    {byte_select_hi, byte_select_lo} <= bs;
    step(10);
    write_strobe_n <= 1'b0;
    step(8);
    #1 busy_seen = (ready_busy_flag === 1'b0);
    step(2);
    write_strobe_n <= 1'b1;
    step(2);
  endtask
  task automatic wait_rdy(output logic ok);
    int k;
    k = 0;
    while (ready_busy_flag !== 1'b1 && k < 1000) begin
      @(posedge clk);
      #1 k++;
    end
    ok = (ready_busy_flag === 1'b1);
  endtask
  task automatic rd(input logic [1:0] bs, output logic [7:0] v, output logic oe);
    @(posedge clk);
    {byte_select_hi, byte_select_lo} <= bs;
    data_out_enable_n <= 1'b0;
    step(10);
    #1 v = data_bus;
    oe = data_oe;
    @(posedge clk);
    data_out_enable_n <= 1'b1;
    step(10);
  endtask
endmodule // ppp_prog_model
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the parallel programming port
`include "ppp_defines.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] adr;
    logic [1:0] bs;
    logic [7:0] exp;
  } ppp_row_t;
  localparam ppp_row_t ROWS [8] = '{
    '{`PPP_CMD_RD_FUSE, 8'h00, `PPP_RD_FUSE_LO, `PPP_FUSE_LO_RST},
    '{`PPP_CMD_RD_FUSE, 8'h00, `PPP_RD_LOCK, 8'hFF},
    '{`PPP_CMD_RD_FUSE, 8'h00, `PPP_RD_FUSE_EXT, `PPP_FUSE_EXT_RST},
    '{`PPP_CMD_RD_FUSE, 8'h00, `PPP_RD_FUSE_HI, `PPP_FUSE_HI_RST},
    '{`PPP_CMD_RD_SIG, 8'h00, 2'h0, 8'h5A},
    '{`PPP_CMD_RD_SIG, 8'h01, 2'h0, 8'h3C},
    '{`PPP_CMD_RD_SIG, 8'h02, 2'h0, 8'h6B},
    '{`PPP_CMD_RD_SIG, 8'h00, 2'h1, 8'h80}};
  logic       clk;
  logic       reset;
  wire  [7:0] data_bus, data_out;
  wire        hv, cs, xa0, xa1, bs_lo, bs_hi, latch, wr_n, oe_n;
  wire        data_oe, rdy, prog_mode;
  int         bad_count = 0;
  int         checked = 0;
  // signature values are arbitrary
  ppp_top #(.FLASH_AW(8), .EEP_AW(8), .SIG_BYTE0(8'h5A), .SIG_BYTE1(8'h3C),
    .SIG_BYTE2(8'h6B)) i_dut (
    .clk(clk), .reset(reset), .hv_reset_detect(hv), .clock_strobe_input(cs),
    .strobe_action_0(xa0), .strobe_action_1(xa1), .byte_select_lo(bs_lo),
    .byte_select_hi(bs_hi), .page_buffer_latch(latch), .write_strobe_n(wr_n),
    .data_out_enable_n(oe_n), .data_in(data_bus), .data_out(data_out),
    .data_oe(data_oe), .ready_busy_flag(rdy), .prog_mode(prog_mode));
  ppp_prog_model i_prog (
    .clk(clk), .data_out(data_out), .data_oe(data_oe), .ready_busy_flag(rdy),
    .data_bus(data_bus), .hv_reset_detect(hv), .clock_strobe_input(cs),
    .strobe_action_0(xa0), .strobe_action_1(xa1), .byte_select_lo(bs_lo),
    .byte_select_hi(bs_hi), .page_buffer_latch(latch), .write_strobe_n(wr_n),
    .data_out_enable_n(oe_n));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    i_prog.load(`PPP_ACT_CMD, 2'h0, c);
  endtask
  task automatic ald(input logic [1:0] bs, input logic [7:0] a);
    i_prog.load(`PPP_ACT_ADDR, bs, a);
  endtask
  task automatic rc(input string what, input logic [1:0] bs, input logic [7:0] exp);
    logic [7:0] v;
    logic       oe;
    i_prog.rd(bs, v, oe);
    check({what, " oe"}, {15'h0000, oe}, 16'h0001);
    check(what, {8'h00, v}, {8'h00, exp});
  endtask
  task automatic wlat(input logic [7:0] a, input logic [15:0] d);
    ald(2'h0, a);
    i_prog.load(`PPP_ACT_DATA, 2'h0, d[7:0]);
    i_prog.load(`PPP_ACT_DATA, 2'h1, d[15:8]);
    i_prog.latch();
  endtask
  task automatic op(input logic [1:0] bs);
    logic ok;
    i_prog.wr(bs);
    check("busy seen", {15'h0000, i_prog.busy_seen}, 16'h0001);
    i_prog.wait_rdy(ok);
    check("ready back", {15'h0000, ok}, 16'h0001);
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial begin
    reset = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 check("reset state", {13'h0000, data_oe, prog_mode, rdy}, 16'h0000);
    i_prog.enter(4'h0, 1'b0);
    check("entered", {14'h0000, prog_mode, rdy}, 16'h0003);
    for (int i = 0; i < 8; i++) begin
      cmd(ROWS[i].cmd);
      ald(2'h0, ROWS[i].adr);
      rc("row read", ROWS[i].bs, ROWS[i].exp);
    end
    cmd(`PPP_CMD_ERASE);
    op(2'h0);
    cmd(`PPP_CMD_RD_FLASH);
    ald(2'h1, 8'h00);
    ald(2'h0, 8'h41);
    rc("flash blank", 2'h0, `PPP_ERASED_BYTE);
    cmd(`PPP_CMD_WR_FLASH);
    wlat(8'h41, 16'h1234);
    wlat(8'h7F, 16'h5678);
    ald(2'h3, 8'h00);
    op(2'h0);
    cmd(`PPP_CMD_RD_FLASH);
    rc("flash w63 hi", 2'h1, 8'h56);
    ald(2'h0, 8'h41);
    rc("flash w1 lo", 2'h0, 8'h34);
    rc("flash w1 hi", 2'h1, 8'h12);
    ald(2'h0, 8'h01);
    rc("other page", 2'h0, `PPP_ERASED_BYTE);
    cmd(8'h55);
    ald(2'h0, 8'h41);
    rc("unlisted cmd", 2'h0, 8'h34);
    cmd(`PPP_CMD_NOP);
    rc("nop read", 2'h0, 8'h00);
    cmd(`PPP_CMD_WR_EEP);
    ald(2'h0, 8'h06);
    i_prog.load(`PPP_ACT_DATA, 2'h0, 8'hA5);
    i_prog.latch();
    op(2'h0);
    cmd(`PPP_CMD_RD_EEP);
    rc("eep byte", 2'h0, 8'hA5);
    cmd(`PPP_CMD_WR_FUSE);
    i_prog.load(`PPP_ACT_DATA, 2'h0, 8'hF7);
    op(2'h1);
    cmd(`PPP_CMD_WR_LOCK);
    i_prog.load(`PPP_ACT_DATA, 2'h0, 8'hFC);
    op(2'h0);
    cmd(`PPP_CMD_RD_FUSE);
    rc("fuse hi", `PPP_RD_FUSE_HI, 8'hF7);
    rc("lock set", `PPP_RD_LOCK, 8'hFC);
    cmd(`PPP_CMD_ERASE);
    op(2'h0);
    cmd(`PPP_CMD_RD_FUSE);
    rc("lock erased", `PPP_RD_LOCK, 8'hFF);
    rc("fuse kept", `PPP_RD_FUSE_HI, 8'hF7);
    cmd(`PPP_CMD_RD_EEP);
    rc("eep kept", 2'h0, 8'hA5);
    i_prog.leave();
    check("left mode", {14'h0000, prog_mode, rdy}, 16'h0000);
    i_prog.enter(4'h2, 1'b0);
    check("bad pattern", {15'h0000, prog_mode}, 16'h0000);
    i_prog.leave();
    i_prog.enter(4'h0, 1'b1);
    check("glitch entry", {15'h0000, prog_mode}, 16'h0000);
    stop_test();
  end
endmodule // tb
`default_nettype wire
